// file: indwd_cfg.svh
`ifndef INDWD_CFG_SVH
`define INDWD_CFG_SVH

// Register byte offsets.
`define INDWD_OFS_KEY 8'h00
`define INDWD_OFS_PRESC 8'h04
`define INDWD_OFS_RELOAD 8'h08
`define INDWD_OFS_STATUS 8'h0c
`define INDWD_OFS_IRQ_STAT 8'h10
`define INDWD_OFS_IRQ_CLR 8'h14
`define INDWD_OFS_IRQ_EN 8'h18
`define INDWD_OFS_COUNT 8'h1c

// Key values.
`define INDWD_KEY_REFRESH 16'haaaa
`define INDWD_KEY_UNLOCK 16'h5555
`define INDWD_KEY_START 16'hcccc

// Field positions.
`define INDWD_PVU_BIT 0
`define INDWD_RVU_BIT 1
`define INDWD_RUN_BIT 12
`define INDWD_EV_PVU 0
`define INDWD_EV_RVU 1
`define INDWD_EV_TIMEOUT 2

// Reset values.
`define INDWD_PRESC_RST 3'h0
`define INDWD_RELOAD_RST 12'hfff
`define INDWD_COUNT_START 12'hfff

// Timing counts, in low-speed oscillator cycles.
`define INDWD_XFER_TICKS 3'h2
`define INDWD_PRESC_BASE 9'h004
`define INDWD_PRESC_MAX_CODE 3'h6

`endif

// file: indwd_chk.sv
`timescale 1ns/1ps
`default_nettype none
module indwd_chk
    import indwd_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire indwd_wb_req_type wb_req,
    input wire indwd_wb_rsp_type wb_rsp,
    input wire logic watchdog_reset
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic rd;
    assign rd = wb_req.cyc && wb_req.stb && !wb_req.we && !wb_rsp.ack;
    a_ack_after_take: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
        else $error("ack missing after request");
    a_ack_one_cycle: assert property (wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack longer than one cycle");
    a_ack_needs_req: assert property (!(wb_req.cyc && wb_req.stb) |=> !wb_rsp.ack)
        else $error("ack without request");
    a_key_reads_zero: assert property (rd && wb_req.adr == 8'h00 |=> wb_rsp.dat == 32'h0)
        else $error("key read not zero");
    a_presc_upper_zero: assert property (rd && wb_req.adr == 8'h04 |=> wb_rsp.dat[31:3] == 29'h0)
        else $error("prescale read upper bits set");
    a_reload_upper_zero: assert property (rd && wb_req.adr == 8'h08 |=> wb_rsp.dat[31:12] == 20'h0)
        else $error("reload read upper bits set");
    a_status_upper_zero: assert property (rd && wb_req.adr == 8'h0c |=> wb_rsp.dat[31:2] == 30'h0)
        else $error("status read upper bits set");
    a_wdg_reset_sticky: assert property (watchdog_reset |=> watchdog_reset)
        else $error("watchdog reset dropped");
endmodule : indwd_chk

bind indwd_regs indwd_chk chk_i (.core_clk(core_clk), .reset_n(reset_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .watchdog_reset(watchdog_reset));
`default_nettype wire

// file: indwd_pkg.sv
package indwd_pkg;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } indwd_wb_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } indwd_wb_rsp_type;

    typedef struct packed {
        indwd_wb_rsp_type rsp;
        logic hw_armed;
        logic unlocked;
        logic running;
        logic start_pend;
        logic refresh_pend;
        logic [2:0] pr_bus;
        logic [2:0] pr_ls;
        logic [2:0] pvu_cnt;
        logic [11:0] rl_bus;
        logic [11:0] rl_ls;
        logic [2:0] rvu_cnt;
        logic [11:0] count;
        logic wdg_reset;
        logic osc_prev;
        logic [2:0] irq_stat;
        logic [2:0] irq_en;
    } indwd_state_type;

    typedef struct packed {
        logic [7:0] count;
    } indwd_presc_state_type;

endpackage : indwd_pkg

// file: indwd_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "indwd_cfg.svh"

module indwd_prescaler
    import indwd_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic osc_tick,
    input wire logic run,
    input wire logic [2:0] prescale_select,
    output logic count_tick
);

    indwd_presc_state_type q;
    indwd_presc_state_type d;
    logic [2:0] code;
    logic [7:0] last;

    always_comb begin
        d = q;
        count_tick = 1'b0;
        // Code 111 saturates at the largest divider.
        code = (prescale_select > `INDWD_PRESC_MAX_CODE) ? `INDWD_PRESC_MAX_CODE : prescale_select;
        last = 8'((`INDWD_PRESC_BASE << code) - 9'h001);
        if (!run) begin
            d.count = 8'h00;
        end else if (osc_tick) begin
            // A compare of at least guards against a divider that shrinks mid-count.
            if (q.count >= last) begin
                d.count = 8'h00;
                count_tick = 1'b1;
            end else begin
                d.count = q.count + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '{count: 8'h00};
        end else begin
            q <= d;
        end
    end

endmodule : indwd_prescaler

`default_nettype wire

// file: indwd_regs.sv
// Operation
// - The key field is write-only and always reads back as zero.
// - Key AAAAh reloads the counter; software must refresh before it reaches zero.
// - Key 5555h opens write access to the prescale and reload registers.
// - Key CCCCh starts the countdown unless the hardware option already runs it.
// - Prescale codes 000 to 110 divide by 4 to 256; code 111 divides by 256.
// - A prescale write is accepted only while its update is not pending.
// - Prescale reads return the low-speed copy, valid once its update is done.
// - Every refresh loads the reload value and the counter counts down from it.
// - A reload write is accepted only while its update is not pending.
// - Reload reads return the low-speed copy, valid once its update is done.
// - The reload pending flag stands during transfer, clearing within five oscillator cycles.
// - The prescale pending flag stands during transfer, clearing within five oscillator cycles.
// - An accepted update completes even if low-power mode is entered meanwhile.
// - Standby reset sets reload to FFFh and clears the key, not the status.
// - Start counts down from FFFh; reaching zero raises the watchdog reset.
// - Any key other than 5555h restores write protection.
// - With the hardware option, the watchdog runs from power-on without a start key.
`timescale 1ns/1ps
`default_nettype none
`include "indwd_cfg.svh"

module indwd_regs
    import indwd_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire indwd_wb_req_type wb_req,
    output indwd_wb_rsp_type wb_rsp,
    input wire logic low_speed_osc,
    input wire logic hw_watchdog_opt,
    input wire logic standby_reset,
    output logic watchdog_reset,
    output logic irq
);

    localparam indwd_state_type STATE_RST = '{
        rsp: '{ack: 1'b0, dat: 32'h0000_0000},
        hw_armed: 1'b0,
        unlocked: 1'b0,
        running: 1'b0,
        start_pend: 1'b0,
        refresh_pend: 1'b0,
        pr_bus: `INDWD_PRESC_RST,
        pr_ls: `INDWD_PRESC_RST,
        pvu_cnt: 3'h0,
        rl_bus: `INDWD_RELOAD_RST,
        rl_ls: `INDWD_RELOAD_RST,
        rvu_cnt: 3'h0,
        count: `INDWD_COUNT_START,
        wdg_reset: 1'b0,
        osc_prev: 1'b0,
        irq_stat: 3'h0,
        irq_en: 3'h0
    };

    indwd_state_type q;
    indwd_state_type d;
    logic osc_tick;
    logic count_tick;
    logic bus_req;
    logic bus_take;
    logic bus_write;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [2:0] events;

    function automatic logic [31:0] wb_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = new_val[8*i +: 8];
            end
        end
        return res;
    endfunction : wb_merge

    // The oscillator arrives synchronous to core_clk, so one register finds its rising edge.
    assign osc_tick = low_speed_osc & ~q.osc_prev;

    indwd_prescaler u_prescaler (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .osc_tick(osc_tick),
        .run(q.running),
        .prescale_select(q.pr_ls),
        .count_tick(count_tick)
    );

    // Read data is taken in the first cycle, writes act on the edge where ack is seen.
    assign bus_req = wb_req.cyc & wb_req.stb;
    assign bus_take = bus_req & ~q.rsp.ack;
    assign bus_write = bus_req & wb_req.we & q.rsp.ack;

    always_comb begin
        rdata = 32'h0000_0000;
        unique case (wb_req.adr)
            `INDWD_OFS_KEY: begin
                rdata = 32'h0000_0000;
            end
            `INDWD_OFS_PRESC: begin
                rdata = {29'h0, q.pr_ls};
            end
            `INDWD_OFS_RELOAD: begin
                rdata = {20'h0, q.rl_ls};
            end
            `INDWD_OFS_STATUS: begin
                rdata[`INDWD_PVU_BIT] = (q.pvu_cnt != 3'h0);
                rdata[`INDWD_RVU_BIT] = (q.rvu_cnt != 3'h0);
            end
            `INDWD_OFS_IRQ_STAT: begin
                rdata = {29'h0, q.irq_stat};
            end
            `INDWD_OFS_IRQ_EN: begin
                rdata = {29'h0, q.irq_en};
            end
            `INDWD_OFS_COUNT: begin
                rdata = {20'h0, q.count};
                rdata[`INDWD_RUN_BIT] = q.running;
            end
            default: begin
                rdata = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        d = q;
        events = 3'h0;
        wdata = 32'h0000_0000;
        d.osc_prev = low_speed_osc;

        d.rsp.ack = bus_take;
        if (bus_take) begin
            d.rsp.dat = rdata;
        end

        // The strap is caught by the first clock after reset, never by the reset itself.
        if (!q.hw_armed) begin
            d.hw_armed = 1'b1;
            if (hw_watchdog_opt) begin
                d.running = 1'b1;
            end
        end

        // Oscillator-domain work happens only on an oscillator edge, and it runs with no
        // help from the bus, so a pending update still lands in low-power mode.
        if (osc_tick) begin
            if (q.pvu_cnt != 3'h0) begin
                d.pvu_cnt = q.pvu_cnt - 3'h1;
                if (q.pvu_cnt == 3'h1) begin
                    d.pr_ls = q.pr_bus;
                    events[`INDWD_EV_PVU] = 1'b1;
                end
            end
            if (q.rvu_cnt != 3'h0) begin
                d.rvu_cnt = q.rvu_cnt - 3'h1;
                if (q.rvu_cnt == 3'h1) begin
                    d.rl_ls = q.rl_bus;
                    events[`INDWD_EV_RVU] = 1'b1;
                end
            end
            if (count_tick && q.running && q.count != 12'h000) begin
                d.count = q.count - 12'h001;
            end
            if (q.start_pend) begin
                d.start_pend = 1'b0;
                d.running = 1'b1;
            end
            if (q.refresh_pend) begin
                d.refresh_pend = 1'b0;
                d.count = d.rl_ls;
            end
        end

        // The reset stays asserted until the system reset clears the whole block.
        if (q.running && q.count == 12'h000 && !q.wdg_reset) begin
            d.wdg_reset = 1'b1;
            events[`INDWD_EV_TIMEOUT] = 1'b1;
        end

        if (bus_write) begin
            unique case (wb_req.adr)
                `INDWD_OFS_KEY: begin
                    wdata = wb_merge(32'h0000_0000, wb_req.dat, wb_req.sel);
                    d.unlocked = (wdata[15:0] == `INDWD_KEY_UNLOCK);
                    if (wdata[15:0] == `INDWD_KEY_REFRESH) begin
                        d.refresh_pend = 1'b1;
                    end
                    if (wdata[15:0] == `INDWD_KEY_START) begin
                        d.start_pend = 1'b1;
                    end
                end
                `INDWD_OFS_PRESC: begin
                    // Writes during a transfer are dropped, so software must poll first.
                    if (q.unlocked && q.pvu_cnt == 3'h0) begin
                        wdata = wb_merge({29'h0, q.pr_bus}, wb_req.dat, wb_req.sel);
                        d.pr_bus = wdata[2:0];
                        d.pvu_cnt = `INDWD_XFER_TICKS;
                    end
                end
                `INDWD_OFS_RELOAD: begin
                    if (q.unlocked && q.rvu_cnt == 3'h0) begin
                        wdata = wb_merge({20'h0, q.rl_bus}, wb_req.dat, wb_req.sel);
                        d.rl_bus = wdata[11:0];
                        d.rvu_cnt = `INDWD_XFER_TICKS;
                    end
                end
                `INDWD_OFS_IRQ_CLR: begin
                    wdata = wb_merge(32'h0000_0000, wb_req.dat, wb_req.sel);
                    d.irq_stat = q.irq_stat & ~wdata[2:0];
                end
                `INDWD_OFS_IRQ_EN: begin
                    wdata = wb_merge({29'h0, q.irq_en}, wb_req.dat, wb_req.sel);
                    d.irq_en = wdata[2:0];
                end
                default: begin
                    d.irq_en = q.irq_en;
                end
            endcase
        end

        // Standby leaves the update flags alone so that a transfer in flight finishes.
        if (standby_reset) begin
            d.rl_bus = `INDWD_RELOAD_RST;
            d.rl_ls = `INDWD_RELOAD_RST;
            d.unlocked = 1'b0;
            d.refresh_pend = 1'b0;
            d.start_pend = 1'b0;
        end

        // An event in the same cycle as its clear still sets the bit.
        d.irq_stat = d.irq_stat | events;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    assign wb_rsp = q.rsp;
    assign watchdog_reset = q.wdg_reset;
    assign irq = |(q.irq_stat & q.irq_en);

endmodule : indwd_regs

`default_nettype wire

// file: indwd_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module indwd_regs_bench
    import indwd_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic low_speed_osc = 1'b0;
    logic hw_watchdog_opt = 1'b0;
    logic standby_reset = 1'b0;
    logic [3:0] osc_div = 4'h0;
    indwd_wb_req_type wb_req = '0;
    indwd_wb_rsp_type wb_rsp;
    logic watchdog_reset;
    logic irq;
    int err_total = 0;
    int compares = 0;
    int ticks = 0;
    int t0;
    logic [31:0] q;
    logic [11:0] rv;

    indwd_regs DUT (.core_clk(core_clk), .reset_n(reset_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
        .low_speed_osc(low_speed_osc), .hw_watchdog_opt(hw_watchdog_opt), .standby_reset(standby_reset),
        .watchdog_reset(watchdog_reset), .irq(irq));

    initial begin
        forever #10 core_clk = ~core_clk;
    end

    // The oscillator runs at a sixteenth of the core clock so pending windows outlast a bus read.
    always @(posedge core_clk) begin
        osc_div <= osc_div + 4'h1;
        low_speed_osc <= osc_div[3];
        ticks <= ticks + 1;
        if (ticks == 20000) begin
            err_total++;
            test_done();
        end
    end

    task automatic test_done();
        if (err_total == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic ok(input logic c);
        chk({31'h0, c}, 32'h1);
    endtask : ok

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 20);
        ok(wb_rsp.ack);
        q = wb_rsp.dat;
        wb_req <= '0;
        @(posedge core_clk);
    endtask : wb

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0);
        chk(q, exp);
    endtask : rd

    task automatic wait_for(input logic [7:0] adr, input int b, input logic v);
        t0 = ticks;
        do begin
            wb(1'b0, adr, 32'h0);
        end while (q[b] !== v && ticks - t0 < 4000);
        ok(q[b] === v);
    endtask : wait_for

    function automatic int span(input int steps, input logic [2:0] c);
        return steps * ((c >= 3'h6) ? 256 : (4 << c)) * 16;
    endfunction : span

    initial begin
        void'($urandom(32'hea3d));
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0000_0fff);
        rd(8'h0c, 32'h0);
        rd(8'h20, 32'h0);
        rv = 12'($urandom());
        wb(1'b1, 8'h08, {20'h0, rv});
        rd(8'h08, 32'h0000_0fff);
        wb(1'b1, 8'h00, 32'h5555);
        wb(1'b1, 8'h18, 32'h1);
        for (int c = 0; c < 8; c++) begin
            wb(1'b1, 8'h04, 32'(c));
            wb(1'b1, 8'h04, 32'(7 - c));
            rd(8'h0c, 32'h1);
            wait_for(8'h0c, 0, 1'b0);
            ok(ticks - t0 <= 90);
            rd(8'h04, 32'(c));
        end
        ok(irq);
        wb(1'b1, 8'h18, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, 8'h18, 32'h1);
        wb(1'b1, 8'h14, 32'h1);
        chk({31'h0, irq}, 32'h0);
        rd(8'h10, 32'h0);
        rv = 12'($urandom());
        wb(1'b1, 8'h08, {20'h0, rv});
        wb(1'b1, 8'h08, {20'h0, ~rv});
        rd(8'h0c, 32'h2);
        wait_for(8'h0c, 1, 1'b0);
        ok(ticks - t0 <= 90);
        rd(8'h08, {20'h0, rv});
        wb(1'b1, 8'h00, 32'h1234);
        wb(1'b1, 8'h08, 32'h0);
        rd(8'h0c, 32'h0);
        rd(8'h08, {20'h0, rv});
        // A prescale update is left in flight across standby to show that it still lands.
        wb(1'b1, 8'h00, 32'h5555);
        wb(1'b1, 8'h04, 32'h3);
        standby_reset <= 1'b1;
        @(posedge core_clk);
        standby_reset <= 1'b0;
        @(posedge core_clk);
        rd(8'h08, 32'h0000_0fff);
        rd(8'h0c, 32'h1);
        wait_for(8'h0c, 0, 1'b0);
        rd(8'h04, 32'h3);
        wb(1'b1, 8'h00, 32'h5555);
        wb(1'b1, 8'h08, 32'h10);
        wait_for(8'h0c, 1, 1'b0);
        wb(1'b1, 8'h04, 32'h1);
        wait_for(8'h0c, 0, 1'b0);
        wb(1'b1, 8'h18, 32'h4);
        chk({31'h0, watchdog_reset}, 32'h0);
        wb(1'b1, 8'h00, 32'hcccc);
        wait_for(8'h1c, 12, 1'b1);
        chk(q, 32'h1fff);
        wb(1'b1, 8'h00, 32'haaaa);
        wait_for(8'h1c, 11, 1'b0);
        ok(q[11:0] <= 12'h010 && q[11:0] >= 12'h00f);
        t0 = ticks;
        while (watchdog_reset !== 1'b1 && ticks - t0 < span(18, 3'h1)) @(posedge core_clk);
        ok(ticks - t0 >= span(15, 3'h1) && ticks - t0 <= span(17, 3'h1) + 32);
        ok(irq);
        reset_n <= 1'b0;
        hw_watchdog_opt <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk({31'h0, watchdog_reset}, 32'h0);
        wb(1'b0, 8'h1c, 32'h0);
        ok(q[12]);
        test_done();
    end
endmodule : indwd_regs_bench
`default_nettype wire
